// file: rtl/fseq_defines.vh
// Constants for the flash program/erase sequencer: command codes,
// timing-clock limits, per-command tick counts and state codes.
// Assumes inclusion by bare name from the rtl/ modules only.
`ifndef FSEQ_DEFINES_VH
`define FSEQ_DEFINES_VH

// Core clock rate and permitted timing-clock window, in Hz
`define FSEQ_CORE_CLK_HZ 100000000
`define FSEQ_FLASH_TIMING_CLOCK_MIN_HZ 150000
`define FSEQ_FLASH_TIMING_CLOCK_MAX_HZ 200000

// Command codes
`define FSEQ_CMD_BLANK 8'h05
`define FSEQ_CMD_BYTE_PROG 8'h20
`define FSEQ_CMD_BURST_PROG 8'h25
`define FSEQ_CMD_SECT_ERASE 8'h40
`define FSEQ_CMD_MASS_ERASE 8'h41
`define FSEQ_CMD_ERASE_ABORT 8'h47

// Command durations in timing-clock periods
`define FSEQ_BYTE_TICKS 16'h0009
`define FSEQ_BURST_TICKS 16'h0004
`define FSEQ_ABORT_TICKS 16'h0004
`define FSEQ_SECT_TICKS 16'h0fa0
`define FSEQ_MASS_TICKS 16'h4e20
`define FSEQ_BLANK_TICKS 16'h0004

// Sequencer states, one-hot
`define FSEQ_ST_IDLE 4'h1
`define FSEQ_ST_LATCHED 4'h2
`define FSEQ_ST_ARMED 4'h4
`define FSEQ_ST_RUN 4'h8

`endif

// file: rtl/fseq_timebase.v
// Timing-clock generator: one-cycle tick every (divider + 1) core cycles.
// Assumes run restarts the phase so each command sees whole periods.
`timescale 1ns/1ps

module fseq_timebase #(
    parameter DIV_W = 10
) (
    input wire core_clk, // Core clock
    input wire resetn, // Synchronous reset, active low
    input wire ce, // Clock enable, freezes state when low
    input wire run, // Count while high, restart phase when low
    input wire [DIV_W-1:0] div, // Period minus one, in core cycles
    output wire tick // One-cycle pulse per timing-clock period
);

    reg [DIV_W-1:0] cnt_q;

    assign tick = run && (cnt_q == div);

    // Period counter
    always @(posedge core_clk) begin
        if (!resetn) begin
            cnt_q <= {DIV_W{1'b0}};
        end else if (ce) begin
            if (!run || tick) begin
                cnt_q <= {DIV_W{1'b0}};
            end else begin
                cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // fseq_timebase

// file: rtl/fseq_sequencer.v
// Flash program/erase command sequencer with one-time timing divider.
// Assumes bus-side write strobes are one-cycle pulses on core_clk and
// that the flash array reacts to the high-voltage enables it drives.
//
// Summary of operation
// - Refuse commands until divider gives 150-200 kHz
// - Divider accepts one write after reset only
// - Pulses timed in whole timing-clock periods
// - Byte program 9, burst/abort 4 periods
// - Sector erase 4000, mass erase 20000 periods
// - Array write first; address and data latched
// - Erase and blank check ignore latched data
// - Codes 0x05, 0x20, 0x25 recognised
// - Codes 0x40, 0x41; 0x47 only as sector-erase abort
// - Command write captured, must follow array write
// - Mass erase only when nothing protected
`timescale 1ns/1ps
`include "fseq_defines.vh"

module fseq_sequencer #(
    parameter DIV_W = 10,
    parameter AW = 16,
    parameter [15:0] SECT_TICKS = `FSEQ_SECT_TICKS,
    parameter [15:0] MASS_TICKS = `FSEQ_MASS_TICKS
) (
    input wire core_clk, // Core clock, 100 MHz
    input wire resetn, // Synchronous reset, active low
    input wire ce, // Clock enable
    input wire div_wr, // Divider write strobe
    input wire [DIV_W-1:0] div_val, // Divider value, period minus one
    input wire arr_wr, // Array write strobe
    input wire [AW-1:0] arr_addr, // Array write address
    input wire [7:0] arr_data, // Array write data
    input wire cmd_wr, // Command code write strobe
    input wire [7:0] cmd_code, // Command code
    input wire launch, // Launch strobe
    input wire err_clr, // Clear access error flag
    input wire done_clr, // Clear completion flag
    input wire blk_protected, // Some part of the block is protected
    output reg divider_locked, // Divider has been written
    output wire flash_timing_clock_ok, // Divider written and in range
    output reg access_error_flag, // Sticky access error
    output reg cmd_done_flag, // Sticky command complete
    output reg abort_flag, // Sticky: sector erase was aborted
    output wire busy, // Command running
    output wire flash_timing_clock_tick, // Timing-clock tick
    output reg hv_prog, // Program voltage enable
    output reg hv_erase, // Erase voltage enable
    output reg [AW-1:0] flash_addr, // Latched address
    output reg [7:0] flash_data // Latched data
);

    // Period limits in core cycles: shortest rounds up, longest down
    localparam integer PER_MIN =
        (`FSEQ_CORE_CLK_HZ + `FSEQ_FLASH_TIMING_CLOCK_MAX_HZ - 1) / `FSEQ_FLASH_TIMING_CLOCK_MAX_HZ;
    localparam integer PER_MAX = `FSEQ_CORE_CLK_HZ / `FSEQ_FLASH_TIMING_CLOCK_MIN_HZ;

    reg [DIV_W-1:0] div_q;
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [7:0] cmd_q;
    reg [15:0] rem_q;
    reg err_set;
    wire [31:0] period;
    wire in_run;
    wire run_last;
    wire abort_hit;

    // Code recognition
    function is_valid;
        input [7:0] code;
        begin
            case (code)
                `FSEQ_CMD_BLANK, `FSEQ_CMD_BYTE_PROG, `FSEQ_CMD_BURST_PROG: is_valid = 1'b1;
                `FSEQ_CMD_SECT_ERASE, `FSEQ_CMD_MASS_ERASE: is_valid = 1'b1;
                default: is_valid = 1'b0;
            endcase
        end
    endfunction

    // Duration of each command in timing-clock periods
    function [15:0] ticks_for;
        input [7:0] code;
        begin
            case (code)
                `FSEQ_CMD_BYTE_PROG: ticks_for = `FSEQ_BYTE_TICKS;
                `FSEQ_CMD_BURST_PROG: ticks_for = `FSEQ_BURST_TICKS;
                `FSEQ_CMD_SECT_ERASE: ticks_for = SECT_TICKS;
                `FSEQ_CMD_MASS_ERASE: ticks_for = MASS_TICKS;
                `FSEQ_CMD_ERASE_ABORT: ticks_for = `FSEQ_ABORT_TICKS;
                default: ticks_for = `FSEQ_BLANK_TICKS;
            endcase
        end
    endfunction

    // Programming operations drive the program voltage
    function is_prog;
        input [7:0] code;
        begin
            is_prog = (code == `FSEQ_CMD_BYTE_PROG) || (code == `FSEQ_CMD_BURST_PROG);
        end
    endfunction

    // Timing clock window check
    assign period = {{(32-DIV_W){1'b0}}, div_q} + 32'd1;
    assign flash_timing_clock_ok = divider_locked && (period >= PER_MIN) && (period <= PER_MAX);

    assign in_run = (state_q == `FSEQ_ST_RUN);
    assign busy = in_run;
    assign run_last = in_run && flash_timing_clock_tick && (rem_q == 16'h0001);
    assign abort_hit = in_run && cmd_wr && (cmd_code == `FSEQ_CMD_ERASE_ABORT)
        && (cmd_q == `FSEQ_CMD_SECT_ERASE);

    fseq_timebase #(
        .DIV_W(DIV_W)
    ) u_timebase (
        .core_clk(core_clk),
        .resetn(resetn),
        .ce(ce),
        .run(in_run),
        .div(div_q),
        .tick(flash_timing_clock_tick)
    );

    // Next state and error detection
    always @* begin
        state_d = state_q;
        err_set = 1'b0;
        case (state_q)
            `FSEQ_ST_IDLE: begin
                if (cmd_wr || launch) begin
                    err_set = 1'b1;
                end else if (arr_wr && !access_error_flag) begin
                    state_d = `FSEQ_ST_LATCHED;
                end
            end
            `FSEQ_ST_LATCHED: begin
                if (arr_wr || launch) begin
                    err_set = 1'b1;
                    state_d = `FSEQ_ST_IDLE;
                end else if (cmd_wr) begin
                    if (is_valid(cmd_code)) begin
                        state_d = `FSEQ_ST_ARMED;
                    end else begin
                        err_set = 1'b1;
                        state_d = `FSEQ_ST_IDLE;
                    end
                end
            end
            `FSEQ_ST_ARMED: begin
                if (arr_wr || cmd_wr) begin
                    err_set = 1'b1;
                    state_d = `FSEQ_ST_IDLE;
                end else if (launch) begin
                    if (!flash_timing_clock_ok) begin
                        err_set = 1'b1;
                        state_d = `FSEQ_ST_IDLE;
                    end else if ((cmd_q == `FSEQ_CMD_MASS_ERASE) && blk_protected) begin
                        err_set = 1'b1;
                        state_d = `FSEQ_ST_IDLE;
                    end else begin
                        state_d = `FSEQ_ST_RUN;
                    end
                end
            end
            `FSEQ_ST_RUN: begin
                if (arr_wr || launch || (cmd_wr && !abort_hit)) begin
                    err_set = 1'b1;
                end
                if (run_last) begin
                    state_d = `FSEQ_ST_IDLE;
                end
            end
            default: begin
                state_d = `FSEQ_ST_IDLE;
            end
        endcase
    end

    // Divider: one write after reset, later writes ignored
    always @(posedge core_clk) begin
        if (!resetn) begin
            div_q <= {DIV_W{1'b0}};
            divider_locked <= 1'b0;
        end else if (ce) begin
            if (div_wr && !divider_locked) begin
                div_q <= div_val;
                divider_locked <= 1'b1;
            end
        end
    end

    // State, latched operands and command buffer
    always @(posedge core_clk) begin
        if (!resetn) begin
            state_q <= `FSEQ_ST_IDLE;
            cmd_q <= 8'h00;
            flash_addr <= {AW{1'b0}};
            flash_data <= 8'h00;
        end else if (ce) begin
            state_q <= state_d;
            if ((state_q == `FSEQ_ST_IDLE) && (state_d == `FSEQ_ST_LATCHED)) begin
                flash_addr <= arr_addr;
                flash_data <= arr_data;
            end
            if ((state_q == `FSEQ_ST_LATCHED) && (state_d == `FSEQ_ST_ARMED)) begin
                cmd_q <= cmd_code;
            end else if (abort_hit) begin
                cmd_q <= `FSEQ_CMD_ERASE_ABORT;
            end
        end
    end

    // Remaining period count for the running command
    always @(posedge core_clk) begin
        if (!resetn) begin
            rem_q <= 16'h0000;
        end else if (ce) begin
            if ((state_q == `FSEQ_ST_ARMED) && (state_d == `FSEQ_ST_RUN)) begin
                rem_q <= ticks_for(cmd_q);
            end else if (abort_hit) begin
                rem_q <= `FSEQ_ABORT_TICKS;
            end else if (in_run && flash_timing_clock_tick) begin
                rem_q <= rem_q - 16'h0001;
            end
        end
    end

    // High-voltage enables; data only matters for programming
    always @(posedge core_clk) begin
        if (!resetn) begin
            hv_prog <= 1'b0;
            hv_erase <= 1'b0;
        end else if (ce) begin
            hv_prog <= (state_d == `FSEQ_ST_RUN) && is_prog(cmd_q);
            hv_erase <= (state_d == `FSEQ_ST_RUN) && !abort_hit
                && ((cmd_q == `FSEQ_CMD_SECT_ERASE) || (cmd_q == `FSEQ_CMD_MASS_ERASE));
        end
    end

    // Sticky flags; a new event wins over a clear in the same cycle
    always @(posedge core_clk) begin
        if (!resetn) begin
            access_error_flag <= 1'b0;
            cmd_done_flag <= 1'b0;
            abort_flag <= 1'b0;
        end else if (ce) begin
            if (err_set) begin
                access_error_flag <= 1'b1;
            end else if (err_clr) begin
                access_error_flag <= 1'b0;
            end
            if (run_last) begin
                cmd_done_flag <= 1'b1;
            end else if (done_clr || launch) begin
                cmd_done_flag <= 1'b0;
            end
            if (abort_hit) begin
                abort_flag <= 1'b1;
            end else if (done_clr) begin
                abort_flag <= 1'b0;
            end
        end
    end

endmodule // fseq_sequencer

// file: test/fseq_sequencer_checker.sv
// Checker for the flash sequencer: locking, refusals and run timing.
// Assumes one clock domain and a timing-clock period of at least nine cycles.
`timescale 1ns/1ps
module fseq_sequencer_checker #(parameter AW = 16) (
    input wire core_clk, // Clock
    input wire resetn, // Reset, low
    input wire ce, // Enable
    input wire div_wr, // Divider strobe
    input wire launch, // Launch
    input wire cmd_wr, // Command strobe
    input wire [7:0] cmd_code, // Code
    input wire divider_locked, // Locked
    input wire flash_timing_clock_ok, // Divider ok
    input wire access_error_flag, // Error
    input wire cmd_done_flag, // Done
    input wire abort_flag, // Aborted
    input wire busy, // Running
    input wire flash_timing_clock_tick, // Tick
    input wire [AW-1:0] flash_addr // Latched address
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Divider locking and refusal of commands
    lock_hold_a: assert property (divider_locked |=> divider_locked)
        else $error("divider lock lost");
    div_take_a: assert property (ce && div_wr |=> divider_locked)
        else $error("divider write not taken");
    run_gate_a: assert property ($rose(busy) |-> flash_timing_clock_ok)
        else $error("run started without valid divider");
    launch_ref_a: assert property (ce && launch && !flash_timing_clock_ok && !busy |=> access_error_flag)
        else $error("launch without divider not refused");
    code_ref_a: assert property (ce && cmd_wr && !busy &&
        !(cmd_code inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41}) |=> access_error_flag)
        else $error("bad code not refused");
    // Timing pulses and completion
    tick_busy_a: assert property (flash_timing_clock_tick |-> busy)
        else $error("tick outside a run");
    tick_space_a: assert property (flash_timing_clock_tick |=> !flash_timing_clock_tick [*8])
        else $error("ticks too close");
    end_tick_a: assert property ($fell(busy) |-> $past(flash_timing_clock_tick))
        else $error("run ended off a tick");
    done_flag_a: assert property ($fell(busy) |-> cmd_done_flag || abort_flag)
        else $error("no completion flag");
    latch_hold_a: assert property (busy |=> $stable(flash_addr))
        else $error("address changed in run");
endmodule // fseq_sequencer_checker

bind fseq_sequencer fseq_sequencer_checker #(.AW(AW)) u_chk (.core_clk(core_clk),
    .resetn(resetn), .ce(ce), .div_wr(div_wr), .launch(launch), .cmd_wr(cmd_wr),
    .cmd_code(cmd_code), .divider_locked(divider_locked), .flash_timing_clock_ok(flash_timing_clock_ok),
    .access_error_flag(access_error_flag), .cmd_done_flag(cmd_done_flag),
    .abort_flag(abort_flag), .busy(busy), .flash_timing_clock_tick(flash_timing_clock_tick), .flash_addr(flash_addr));

// file: test/fseq_cpu_model.sv
// Bus software model: divider write, array write, command, launch.
// Assumes tasks are called 1 ns after a rising edge, one at a time.
`timescale 1ns/1ps
module fseq_cpu_model (
    input wire core_clk, // Clock
    output logic div_wr = 1'b0, // Divider strobe
    output logic [9:0] div_val = 10'h000, // Divider value
    output logic arr_wr = 1'b0, // Array strobe
    output logic [15:0] arr_addr = 16'h0000, // Array address
    output logic [7:0] arr_data = 8'h00, // Array data
    output logic cmd_wr = 1'b0, // Command strobe
    output logic [7:0] cmd_code = 8'h00, // Command code
    output logic launch = 1'b0, // Launch strobe
    output logic err_clr = 1'b0, // Error clear
    output logic done_clr = 1'b0 // Done clear
);
    // One cycle, inputs move just after the edge
    task automatic step;
        @(posedge core_clk);
        #1;
    endtask
    // Clear stale flags before divider or command work
    task automatic clear;
        err_clr = 1'b1;
        done_clr = 1'b1;
        step;
        err_clr = 1'b0;
        done_clr = 1'b0;
    endtask
    // One-time divider write; idle value is scrambled
    task automatic wr_div(input logic [9:0] v);
        clear;
        div_wr = 1'b1;
        div_val = v;
        step;
        div_wr = 1'b0;
        div_val = ~v;
    endtask
    // Command code write alone
    task automatic cmd_only(input logic [7:0] c);
        cmd_wr = 1'b1;
        cmd_code = c;
        step;
        cmd_wr = 1'b0;
        cmd_code = ~c;
    endtask
    // Array write, then command, then launch
    task automatic seq(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c);
        clear;
        arr_wr = 1'b1;
        arr_addr = a;
        arr_data = d;
        step;
        arr_wr = 1'b0;
        arr_addr = ~a;
        arr_data = ~d;
        cmd_only(c);
        launch = 1'b1;
        step;
        launch = 1'b0;
    endtask
endmodule // fseq_cpu_model

// file: test/flash_program_erase_sequencer_test.sv
// Testbench for the flash sequencer with a bus software model.
// Assumes 100 MHz clock; sector and mass counts shortened to 12 and 8.
`timescale 1ns/1ps
module flash_program_erase_sequencer_test;
    localparam int PER = 500;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic blk_protected = 1'b0;
    wire div_wr, arr_wr, cmd_wr, launch, err_clr, done_clr, hv_prog, hv_erase, flash_timing_clock_tick;
    wire divider_locked, flash_timing_clock_ok, access_error_flag, cmd_done_flag, abort_flag, busy;
    wire [9:0] div_val;
    wire [15:0] arr_addr, flash_addr;
    wire [7:0] arr_data, cmd_code, flash_data;
    int num_errors = 0;
    int compares = 0;
    int cnt;
    int tk;
    // Clock
    always #5 core_clk = ~core_clk;
    fseq_cpu_model cpu (.core_clk(core_clk), .div_wr(div_wr), .div_val(div_val),
        .arr_wr(arr_wr), .arr_addr(arr_addr), .arr_data(arr_data), .cmd_wr(cmd_wr),
        .cmd_code(cmd_code), .launch(launch), .err_clr(err_clr), .done_clr(done_clr));
    fseq_sequencer #(.SECT_TICKS(16'h000c), .MASS_TICKS(16'h0008)) DUT (
        .core_clk(core_clk), .resetn(resetn), .ce(ce), .div_wr(div_wr), .div_val(div_val),
        .arr_wr(arr_wr), .arr_addr(arr_addr), .arr_data(arr_data), .cmd_wr(cmd_wr),
        .cmd_code(cmd_code), .launch(launch), .err_clr(err_clr), .done_clr(done_clr),
        .blk_protected(blk_protected), .divider_locked(divider_locked), .flash_timing_clock_ok(flash_timing_clock_ok),
        .access_error_flag(access_error_flag), .cmd_done_flag(cmd_done_flag),
        .abort_flag(abort_flag), .busy(busy), .flash_timing_clock_tick(flash_timing_clock_tick), .hv_prog(hv_prog),
        .hv_erase(hv_erase), .flash_addr(flash_addr), .flash_data(flash_data));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic do_reset;
        resetn = 1'b0;
        repeat (8) cpu.step;
        resetn = 1'b1;
    endtask
    // Count remaining busy cycles and timing ticks seen in them
    task automatic run_len;
        cnt = 0;
        tk = 0;
        while (busy === 1'b1 && cnt < 30000) begin
            if (flash_timing_clock_tick === 1'b1) tk++;
            cpu.step;
            cnt++;
        end
    endtask
    // Commands before and with a bad divider, second divider write ignored
    task automatic t_no_div;
        cpu.seq(16'h1234, 8'ha5, 8'h20);
        cpu.step;
        chk({access_error_flag, busy}, 2'b10);
        cpu.wr_div(10'd100);
        cpu.seq(16'h1234, 8'ha5, 8'h20);
        cpu.step;
        chk({access_error_flag, busy}, 2'b10);
        cpu.wr_div(10'(PER - 1));
        chk({divider_locked, flash_timing_clock_ok}, 2'b10);
        do_reset;
        cpu.wr_div(10'(PER - 1));
        chk({divider_locked, flash_timing_clock_ok}, 2'b11);
    endtask
    // Every valid command, erases before programs: duration, voltages, latch, completion
    task automatic t_codes;
        logic [7:0] codes [5] = '{8'h05, 8'h40, 8'h41, 8'h20, 8'h25};
        int ticks [5] = '{4, 12, 8, 9, 4};
        for (int i = 0; i < 5; i++) begin
            cpu.seq(16'h0100 + 16'(i), 8'h3c, codes[i]);
            cpu.step;
            chk({hv_prog, hv_erase}, {codes[i][5], codes[i][6]});
            chk(flash_addr, 16'h0100 + 16'(i));
            chk(flash_data, 8'h3c);
            run_len;
            chk(cnt, ticks[i] * PER - 1);
            chk(tk, ticks[i]);
            chk({cmd_done_flag, hv_prog, hv_erase, access_error_flag}, 4'b1000);
        end
    endtask
    // Bad code, lone command, stray abort, protected mass erase
    task automatic t_refuse;
        cpu.seq(16'h0200, 8'h00, 8'h33);
        cpu.step;
        chk(access_error_flag, 1);
        cpu.clear;
        cpu.cmd_only(8'h20);
        cpu.step;
        chk(access_error_flag, 1);
        cpu.clear;
        cpu.cmd_only(8'h47);
        cpu.step;
        chk(access_error_flag, 1);
        blk_protected = 1'b1;
        cpu.seq(16'h0200, 8'h00, 8'h41);
        cpu.step;
        chk({access_error_flag, busy}, 2'b10);
        blk_protected = 1'b0;
    endtask
    // Sector erase aborted after two periods
    task automatic t_abort;
        cpu.seq(16'h0300, 8'h00, 8'h40);
        repeat (2 * PER) cpu.step;
        cpu.cmd_only(8'h47);
        cpu.step;
        chk({abort_flag, hv_erase, access_error_flag}, 3'b100);
        run_len;
        chk(cnt > 3 * PER - 3 && cnt <= 4 * PER, 1);
        chk(tk, 4);
    endtask
    // Clock enable low at run start freezes timing and ignores strobes
    task automatic t_freeze;
        cpu.seq(16'h0400, 8'h5a, 8'h25);
        ce = 1'b0;
        cpu.cmd_only(8'h20);
        repeat (99) cpu.step;
        ce = 1'b1;
        chk({busy, access_error_flag, hv_prog}, 3'b101);
        run_len;
        chk(cnt, 4 * PER);
        chk(tk, 4);
        chk({cmd_done_flag, access_error_flag}, 2'b10);
    endtask
    // Main sequence
    initial begin
        do_reset;
        t_no_div;
        t_codes;
        t_refuse;
        t_abort;
        t_freeze;
        close_out;
    end
    // Watchdog
    initial begin
        #1_000_000;
        num_errors++;
        close_out;
    end
endmodule // flash_program_erase_sequencer_test
